// ===== mmbc_pkg.sv
// Shared constants and types of the minimum-mode local bus controller.
// Assumes a single 100 MHz clock; one processor T-state spans two clock cycles.
package mmbc_pkg;

    // Cycle status codes in the order {io/mem select, direction, status bit 0}.
    localparam logic [2:0] CODE_IRQ_ACK_STROBE_N = 3'h4;
    localparam logic [2:0] CODE_IO_RD = 3'h5;
    localparam logic [2:0] CODE_IO_WR = 3'h6;
    localparam logic [2:0] CODE_HALT = 3'h7;
    localparam logic [2:0] CODE_FETCH = 3'h0;
    localparam logic [2:0] CODE_MEM_RD = 3'h1;
    localparam logic [2:0] CODE_MEM_WR = 3'h2;
    localparam logic [2:0] CODE_PASSIVE = 3'h3;

    // Clock periods per T-state; phase 0 is the first half, phase 1 the second.
    localparam int TSTATE_CLOCKS = 2;

    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_T1 = 7'h02,
        ST_T2 = 7'h04,
        ST_T3 = 7'h08,
        ST_TW = 7'h10,
        ST_T4 = 7'h20,
        ST_HOLD = 7'h40
    } mmbc_state_type;

endpackage

// ===== mmbc_cycle_decode.sv
// Classifies a three-bit cycle status code into the kinds of transfer it needs.
// Assumes the code is stable for the whole bus cycle.
`timescale 1ns/100ps
module mmbc_cycle_decode (
    // Code in
    input wire logic [2:0] code,
    // Classification out
    output logic is_read,
    output logic is_write,
    output logic is_irq_ack_strobe_n
);

    always_comb begin
        is_read = 1'b0;
        is_write = 1'b0;
        is_irq_ack_strobe_n = 1'b0;
        case (code)
            mmbc_pkg::CODE_IRQ_ACK_STROBE_N: is_irq_ack_strobe_n = 1'b1;
            mmbc_pkg::CODE_IO_RD: is_read = 1'b1;
            mmbc_pkg::CODE_IO_WR: is_write = 1'b1;
            mmbc_pkg::CODE_FETCH: is_read = 1'b1;
            mmbc_pkg::CODE_MEM_RD: is_read = 1'b1;
            mmbc_pkg::CODE_MEM_WR: is_write = 1'b1;
            default: is_read = 1'b0; // Halt and passive move no data.
        endcase
    end

endmodule

// ===== mmbc_bus_ctrl.sv
// Minimum-mode local bus control: cycle sequencing, strobes, transceiver control, hold.
// Assumes the core presents cycle requests and the bus inputs synchronous to sys_clk.
//
// Functional notes
// - Minimum-mode functions only when mode select high; the code gates only cycle starts with it, hold is acknowledged either way.
// - IO/memory select valid from preceding T4.
// - Hold releases control lines, retaining logic one.
// - Write strobe low in T2, T3, Tw.
// - Interrupt acknowledge strobe low in T2, T3, Tw.
// - Address latch enable always driven, never released.
// - Direction follows status, high transmit, low receive.
// - Transceiver enable for memory, I/O, acknowledge cycles.
// - Read/acknowledge: enable mid T2 to mid T4.
// - Write: enable start T2 to mid T4.
// - Hold acknowledge raised after T4 or an idle T-state.
// - Release outputs together with hold acknowledge.
// - Drop acknowledge on low request; drive on next cycle.
// - Codes 100 acknowledge, 101 read I/O.
// - Read strobe low T2 (after float), T3, Tw.
`timescale 1ns/100ps
module mmbc_bus_ctrl (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Strap and core request
    input wire logic mode_select_pin,
    input wire logic req_valid,
    input wire logic [2:0] req_code,
    output logic req_taken,
    // Bus inputs
    input wire logic bus_ready,
    input wire logic hold_req,
    // Status and strobes
    output logic io_mem_select,
    output logic xcvr_direction,
    output logic cycle_status_bit0,
    output logic rd_n,
    output logic wr_n,
    output logic irq_ack_strobe_n,
    output logic xcvr_enable_n,
    output logic ctrl_oe,
    // Always driven
    output logic ale,
    output logic bus_hold_ack
);

    mmbc_pkg::mmbc_state_type state_reg;
    mmbc_pkg::mmbc_state_type state_next;
    logic phase_reg;
    logic [2:0] code_reg;
    logic drive_reg;
    logic start_ok;
    logic take;
    logic is_read;
    logic is_write;
    logic is_irq_ack_strobe_n;
    logic [2:0] status_next;

    initial begin
        if (mmbc_pkg::TSTATE_CLOCKS != 2) begin
            $error("Only two clocks per T-state are supported.");
        end
    end

    mmbc_cycle_decode u_mmbc_cycle_decode (
        .code(code_reg),
        .is_read(is_read),
        .is_write(is_write),
        .is_irq_ack_strobe_n(is_irq_ack_strobe_n)
    );

    // Hold request is used as is: the requester owns its synchronisation.
    assign start_ok = mode_select_pin && req_valid && (req_code != mmbc_pkg::CODE_PASSIVE);
    assign take = phase_reg && !hold_req && start_ok &&
        (state_reg == mmbc_pkg::ST_IDLE || state_reg == mmbc_pkg::ST_T4);

    // The T-state divider: state moves only at the end of phase 1.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_reg <= 1'b0;
        end else begin
            phase_reg <= !phase_reg;
        end
    end

    always_comb begin
        state_next = state_reg;
        if (phase_reg) begin
            case (state_reg)
                mmbc_pkg::ST_IDLE, mmbc_pkg::ST_T4: begin
                    if (hold_req) begin
                        state_next = mmbc_pkg::ST_HOLD;
                    end else if (take) begin
                        state_next = mmbc_pkg::ST_T1;
                    end else begin
                        state_next = mmbc_pkg::ST_IDLE;
                    end
                end
                mmbc_pkg::ST_T1: state_next = mmbc_pkg::ST_T2;
                mmbc_pkg::ST_T2: state_next = mmbc_pkg::ST_T3;
                mmbc_pkg::ST_T3, mmbc_pkg::ST_TW: begin
                    state_next = bus_ready ? mmbc_pkg::ST_T4 : mmbc_pkg::ST_TW;
                end
                mmbc_pkg::ST_HOLD: begin
                    if (!hold_req) begin
                        state_next = mmbc_pkg::ST_IDLE;
                    end
                end
                default: state_next = mmbc_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= mmbc_pkg::ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            code_reg <= mmbc_pkg::CODE_PASSIVE;
            req_taken <= 1'b0;
        end else begin
            req_taken <= take;
            if (take) begin
                code_reg <= req_code;
            end
        end
    end

    // Drivers come back only with the next bus cycle, not when hold drops.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            drive_reg <= 1'b0;
        end else if (state_next == mmbc_pkg::ST_HOLD) begin
            drive_reg <= 1'b0;
        end else if (take) begin
            drive_reg <= 1'b1;
        end
    end

    // The status announces a cycle at the edge that takes it, from idle or from T4.
    always_comb begin
        case (state_reg)
            mmbc_pkg::ST_T1, mmbc_pkg::ST_T2, mmbc_pkg::ST_T3, mmbc_pkg::ST_TW: begin
                status_next = code_reg;
            end
            mmbc_pkg::ST_IDLE: status_next = take ? req_code : mmbc_pkg::CODE_PASSIVE;
            mmbc_pkg::ST_T4: status_next = take ? req_code : code_reg;
            default: status_next = mmbc_pkg::CODE_PASSIVE;
        endcase
    end

    // Every pin is registered; the drivers come back at the very edge that takes a cycle.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            io_mem_select <= 1'b1;
            xcvr_direction <= 1'b1;
            cycle_status_bit0 <= 1'b1;
            ctrl_oe <= 1'b0;
        end else if (!drive_reg && !take) begin
            io_mem_select <= 1'b1;
            xcvr_direction <= 1'b1;
            cycle_status_bit0 <= 1'b1;
            ctrl_oe <= 1'b0;
        end else begin
            io_mem_select <= status_next[2];
            xcvr_direction <= status_next[1];
            cycle_status_bit0 <= status_next[0];
            ctrl_oe <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_n <= 1'b1;
            wr_n <= 1'b1;
            irq_ack_strobe_n <= 1'b1;
        end else begin
            // Second half of T2 only: the address has left the bus by then.
            rd_n <= !(is_read && ((state_reg == mmbc_pkg::ST_T2 && phase_reg) ||
                state_reg == mmbc_pkg::ST_T3 || state_reg == mmbc_pkg::ST_TW));
            wr_n <= !(is_write && (state_reg == mmbc_pkg::ST_T2 ||
                state_reg == mmbc_pkg::ST_T3 || state_reg == mmbc_pkg::ST_TW));
            irq_ack_strobe_n <= !(is_irq_ack_strobe_n && (state_reg == mmbc_pkg::ST_T2 ||
                state_reg == mmbc_pkg::ST_T3 || state_reg == mmbc_pkg::ST_TW));
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            xcvr_enable_n <= 1'b1;
        end else if (!drive_reg) begin
            xcvr_enable_n <= 1'b1;
        end else begin
            case (state_reg)
                mmbc_pkg::ST_T2: begin
                    xcvr_enable_n <= !(is_write || ((is_read || is_irq_ack_strobe_n) && phase_reg));
                end
                mmbc_pkg::ST_T3, mmbc_pkg::ST_TW: begin
                    xcvr_enable_n <= !(is_write || is_read || is_irq_ack_strobe_n);
                end
                mmbc_pkg::ST_T4: begin
                    xcvr_enable_n <= !((is_write || is_read || is_irq_ack_strobe_n) && !phase_reg);
                end
                default: xcvr_enable_n <= 1'b1;
            endcase
        end
    end

    // The latch pulse is driven even in hold so the latch never sees a floating input.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ale <= 1'b0;
            bus_hold_ack <= 1'b0;
        end else begin
            ale <= (state_reg == mmbc_pkg::ST_T1) && !phase_reg;
            bus_hold_ack <= (state_reg == mmbc_pkg::ST_HOLD);
        end
    end

    AST_ALE_ONE_CLOCK: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ale |=> !ale ##1 !ale)
        else $error("Latch pulse longer than one clock.");

    AST_ALE_IN_T1: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(ale) |-> $past(state_reg == mmbc_pkg::ST_T1) && ctrl_oe)
        else $error("Latch pulse outside T1.");

    AST_WR_DIR: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !wr_n |-> xcvr_direction && !cycle_status_bit0 && !xcvr_enable_n)
        else $error("Write strobe with wrong status or enable.");

    AST_WR_WIDTH: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $fell(wr_n) |-> !wr_n [*4])
        else $error("Write strobe shorter than T2 and T3.");

    AST_IRQ_ACK_STROBE_N_CODE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !irq_ack_strobe_n |-> {io_mem_select, xcvr_direction, cycle_status_bit0} == 3'h4)
        else $error("Acknowledge strobe with wrong status.");

    AST_RD_DEN: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $fell(rd_n) |-> $past(rd_n, 2) && !xcvr_enable_n && !xcvr_direction)
        else $error("Read strobe early or without enable.");

    AST_DEN_TAIL: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(rd_n) |-> !xcvr_enable_n ##1 xcvr_enable_n)
        else $error("Enable not held into first half of T4.");

    AST_RELEASED_ONE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !ctrl_oe |-> io_mem_select && xcvr_direction && cycle_status_bit0 &&
        rd_n && wr_n && irq_ack_strobe_n && xcvr_enable_n)
        else $error("Released line not at logic one.");

    AST_HOLD_RELEASE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        bus_hold_ack |-> !ctrl_oe)
        else $error("Outputs driven during hold acknowledge.");

    AST_HOLD_DROP: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_reg == mmbc_pkg::ST_HOLD && phase_reg && !hold_req) |-> ##2 !bus_hold_ack)
        else $error("Hold acknowledge not dropped.");

    COV_WRITE: cover property (@(posedge sys_clk) disable iff (!rst_n) $fell(wr_n));
    COV_READ_WAIT: cover property (@(posedge sys_clk) disable iff (!rst_n)
        state_reg == mmbc_pkg::ST_TW && is_read);
    COV_HOLD: cover property (@(posedge sys_clk) disable iff (!rst_n) $fell(bus_hold_ack));

endmodule

// ===== mmbc_far_side_model.sv
// Far side of the local bus: a slow or prompt memory/I/O device and a second bus master.
// Assumes the bench sets the wait states before each cycle and asks for the bus by level.
`timescale 1ns/100ps
module mmbc_far_side_model (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Bench controls
    input wire logic [1:0] wait_states,
    input wire logic hold_want,
    // Bus side
    input wire logic ale,
    output logic bus_ready,
    output logic hold_req
);
    logic [3:0] wait_cnt_reg;

    // Ready stays low long enough to span the requested wait states around the sample point.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_cnt_reg <= 4'h0;
        end else if (ale && wait_states != 2'h0) begin
            wait_cnt_reg <= {1'b0, wait_states, 1'b0} + 4'h3;
        end else if (wait_cnt_reg != 4'h0) begin
            wait_cnt_reg <= wait_cnt_reg - 4'h1;
        end
    end
    assign bus_ready = (wait_cnt_reg == 4'h0);

    // The request is launched on the clock edge, so it always meets setup.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_req <= 1'b0;
        end else begin
            hold_req <= hold_want;
        end
    end
endmodule

// ===== mmbc_bus_ctrl_tb.sv
// Self-checking bench for the minimum-mode bus controller.
// Assumes the far-side model answers ready and hold; expectations follow the cycle timing.
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin mismatches++; \
    $display("Error %s expected %0h seen %0h", nm, ex, got); end end
module mmbc_bus_ctrl_tb;
    logic sys_clk, rst_n, mode_select_pin, req_valid, req_taken, bus_ready, hold_req, hold_want;
    logic io_mem_select, xcvr_direction, cycle_status_bit0, rd_n, wr_n, irq_ack_strobe_n;
    logic xcvr_enable_n, ctrl_oe, ale, bus_hold_ack;
    logic [2:0] req_code;
    logic [1:0] wait_states;
    int mismatches, checked;

    mmbc_bus_ctrl u_mmbc_bus_ctrl (.sys_clk(sys_clk), .rst_n(rst_n),
        .mode_select_pin(mode_select_pin), .req_valid(req_valid), .req_code(req_code),
        .req_taken(req_taken), .bus_ready(bus_ready), .hold_req(hold_req),
        .io_mem_select(io_mem_select), .xcvr_direction(xcvr_direction),
        .cycle_status_bit0(cycle_status_bit0), .rd_n(rd_n), .wr_n(wr_n),
        .irq_ack_strobe_n(irq_ack_strobe_n), .xcvr_enable_n(xcvr_enable_n),
        .ctrl_oe(ctrl_oe), .ale(ale), .bus_hold_ack(bus_hold_ack));
    mmbc_far_side_model u_mmbc_far_side_model (.sys_clk(sys_clk), .rst_n(rst_n),
        .wait_states(wait_states), .hold_want(hold_want), .ale(ale),
        .bus_ready(bus_ready), .hold_req(hold_req));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic end_of_test();
        if (mismatches == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic check_released();
        logic [6:0] lines;
        lines = {io_mem_select, xcvr_direction, cycle_status_bit0,
            rd_n, wr_n, irq_ack_strobe_n, xcvr_enable_n};
        `CHK("released lines", 7'h7F, lines)
        `CHK("ctrl_oe", 1'b0, ctrl_oe)
        `CHK("ale", 1'b0, ale)
    endtask

    // One bus cycle, measured clock by clock from the cycle in which req_taken is high.
    task automatic run_cycle(input logic [2:0] code, input int waits);
        int k, last, n_ale, p_ale, bad, en_w, n[4], f[4];
        logic wr, rd, ia;
        logic [3:0] strb;
        wr = (code == mmbc_pkg::CODE_IO_WR) || (code == mmbc_pkg::CODE_MEM_WR);
        rd = (code == mmbc_pkg::CODE_FETCH) || (code == mmbc_pkg::CODE_MEM_RD) ||
            (code == mmbc_pkg::CODE_IO_RD);
        ia = (code == mmbc_pkg::CODE_IRQ_ACK_STROBE_N);
        last = 8 + 2 * waits;
        n_ale = 0;
        p_ale = 0;
        bad = 0;
        n = '{0, 0, 0, 0};
        f = '{0, 0, 0, 0};
        @(posedge sys_clk);
        wait_states <= waits[1:0];
        req_code <= code;
        req_valid <= 1'b1;
        k = 0;
        while (req_taken !== 1'b1 && k < 20) begin
            @(negedge sys_clk);
            k++;
        end
        `CHK("req_taken", 1'b1, req_taken)
        for (k = 1; k <= last + 4; k++) begin
            if (k > 1) begin
                @(posedge sys_clk);
                req_valid <= 1'b0;
                @(negedge sys_clk);
            end
            if (ale === 1'b1) begin
                n_ale++;
                p_ale = k;
            end
            strb = {wr_n, rd_n, irq_ack_strobe_n, xcvr_enable_n};
            foreach (n[i]) begin
                if (strb[3 - i] === 1'b0) begin
                    n[i]++;
                    if (f[i] == 0) f[i] = k;
                end
            end
            if (k <= last && ({io_mem_select, xcvr_direction, cycle_status_bit0} !== code ||
                ctrl_oe !== 1'b1)) bad++;
        end
        `CHK("status lines", 0, bad)
        `CHK("ale pulses", 1, n_ale)
        `CHK("ale position", 2, p_ale)
        `CHK("wr_n width", wr ? 4 + 2 * waits : 0, n[0])
        `CHK("wr_n start", wr ? 4 : 0, f[0])
        `CHK("rd_n width", rd ? 3 + 2 * waits : 0, n[1])
        `CHK("rd_n start", rd ? 5 : 0, f[1])
        `CHK("irq_ack_strobe_n width", ia ? 4 + 2 * waits : 0, n[2])
        `CHK("irq_ack_strobe_n start", ia ? 4 : 0, f[2])
        en_w = wr ? 5 + 2 * waits : (rd || ia) ? 4 + 2 * waits : 0;
        `CHK("xcvr_enable_n width", en_w, n[3])
        `CHK("xcvr_enable_n start", wr ? 4 : (rd || ia) ? 5 : 0, f[3])
    endtask

    task automatic expect_refused(input logic mode, input logic [2:0] code);
        int hits;
        hits = 0;
        @(posedge sys_clk);
        mode_select_pin <= mode;
        req_code <= code;
        req_valid <= 1'b1;
        repeat (12) begin
            @(negedge sys_clk);
            if (req_taken !== 1'b0 || ale !== 1'b0) hits++;
        end
        @(posedge sys_clk);
        req_valid <= 1'b0;
        mode_select_pin <= 1'b1;
        `CHK("refused request", 0, hits)
    endtask

    task automatic test_hold();
        int k, hits;
        hits = 0;
        @(posedge sys_clk);
        hold_want <= 1'b1;
        for (k = 0; k < 8 && bus_hold_ack !== 1'b1; k++) @(negedge sys_clk);
        `CHK("bus_hold_ack raised", 1'b1, bus_hold_ack)
        check_released();
        @(posedge sys_clk);
        req_code <= mmbc_pkg::CODE_MEM_RD;
        req_valid <= 1'b1;
        repeat (10) begin
            @(negedge sys_clk);
            if (req_taken !== 1'b0 || ale !== 1'b0 || ctrl_oe !== 1'b0) hits++;
        end
        @(posedge sys_clk);
        req_valid <= 1'b0;
        hold_want <= 1'b0;
        `CHK("cycle during hold", 0, hits)
        for (k = 0; k < 6 && bus_hold_ack !== 1'b0; k++) @(negedge sys_clk);
        `CHK("bus_hold_ack dropped", 1'b0, bus_hold_ack)
        repeat (4) @(negedge sys_clk);
        `CHK("ctrl_oe before next cycle", 1'b0, ctrl_oe)
        run_cycle(mmbc_pkg::CODE_MEM_WR, 0);
    endtask

    initial begin
        #100000;
        mismatches++;
        end_of_test();
    end

    initial begin
        mismatches = 0;
        checked = 0;
        rst_n = 1'b0;
        mode_select_pin = 1'b1;
        req_valid = 1'b0;
        req_code = mmbc_pkg::CODE_PASSIVE;
        wait_states = 2'h0;
        hold_want = 1'b0;
        repeat (5) @(posedge sys_clk);
        check_released();
        rst_n <= 1'b1;
        for (int c = 0; c < 8; c++) begin
            if (c != 3) run_cycle(c[2:0], 0);
        end
        run_cycle(mmbc_pkg::CODE_MEM_RD, 1);
        run_cycle(mmbc_pkg::CODE_IO_WR, 2);
        run_cycle(mmbc_pkg::CODE_IRQ_ACK_STROBE_N, 1);
        expect_refused(1'b0, mmbc_pkg::CODE_MEM_RD);
        expect_refused(1'b1, mmbc_pkg::CODE_PASSIVE);
        test_hold();
        end_of_test();
    end
endmodule
